// [hdl/perif_enable_status_regs.sv]
// Wishbone register block for memory interface enables and peripheral state reports.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
module perif_enable_status_regs
  import perif_regs_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  input  wire wb_req_s               wb_req,
  input  wire logic [3:0]            boot_select_field,
  input  wire logic                  sdram_pin_allow,
  input  wire logic                  async_pin_allow,
  input  wire perif_cond_s [NUM_PERIF-1:0] perif_cond,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       sdram_ctrl_enable,
  output logic                       async_mem_port_enable,
  output logic                       sdram_ctrl_ready,
  output logic                       async_mem_port_ready
);

  logic [1:0]  mem_en_r;
  logic [1:0]  mem_en_nxt;
  logic [1:0]  mem_rdy_r;
  logic [4:0]  settle_cnt_r [2];
  logic        boot_load_r;
  logic [2:0]  state_code_r [NUM_PERIF];
  logic [31:0] rdata;

  wire bus_req     = wb_req.cyc & wb_req.stb & ~wb_ack_o;
  wire hit_a       = wb_req.adr == OFS_STATE_REPORT_A;
  wire hit_b       = wb_req.adr == OFS_STATE_REPORT_B;
  wire hit_cfg     = wb_req.adr == OFS_MEM_IF_ENABLE;
  // Writes to the report registers are acknowledged and dropped.
  wire cfg_write   = bus_req & wb_req.we & hit_cfg & wb_req.sel[0];
  wire [1:0] allow = {sdram_pin_allow, async_pin_allow};
  wire [1:0] wr_set = {wb_req.dat[SDRAM_CTRL_ENABLE_BIT], wb_req.dat[ASYNC_MEM_ENABLE_BIT]};

  // Writing zero never clears a set bit; pins that disabled an interface block it.
  assign mem_en_nxt = mem_en_r | (cfg_write ? (wr_set & allow) : 2'h0);

  // Each state code is derived from the live condition of its peripheral.
  function automatic logic [2:0] state_code(input perif_cond_s c);
    logic [2:0] s;
    s = ST_DISABLED;
    if (c.powered_down) begin
      s = ST_POWERDOWN;
    end else if (c.enable_req && !c.enable_done) begin
      s = ST_IN_PROGRESS;
    end else if (c.enable_req) begin
      s = ST_ENABLED;
    end
    return s;
  endfunction

  wire [2:0] sc [NUM_PERIF];
  genvar g;
  generate
    for (g = 0; g < NUM_PERIF; g++) begin : g_state
      assign sc[g] = state_code_r[g];
    end
  endgenerate

  // Index order: 0 PCI, 1 MAC, 2 timer A, 3 timer B, 4 pin I/O, 5 two-wire,
  // 6 serial A, 7 serial B, 8 host port. Memory interfaces have no field.
  wire [31:0] report_a = {2'h0, sc[8], sc[7], sc[6],
                          sc[5], sc[4], sc[3],
                          sc[2], sc[1], 6'h00};
  wire [31:0] report_b = {29'h0, sc[0]};
  wire [31:0] cfg_rd   = {30'h0, mem_en_r};

  assign rdata = hit_a ? report_a : hit_b ? report_b : hit_cfg ? cfg_rd : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (clk_en) begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rdata : 32'h0;
    end
  end

  // The boot strap is taken by a clocked load in the first enabled cycle after reset,
  // so the reset itself only loads constants.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mem_en_r    <= MEM_ENABLE_RESET;
      boot_load_r <= 1'b1;
    end else if (clk_en) begin
      boot_load_r <= 1'b0;
      if (boot_load_r) begin
        mem_en_r <= mem_en_nxt | {1'b0, (boot_select_field == BOOT_ROM8_CODE)};
      end else begin
        mem_en_r <= mem_en_nxt;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < NUM_PERIF; i++) begin
        state_code_r[i] <= STATE_RESET_VALUE;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NUM_PERIF; i++) begin
        state_code_r[i] <= state_code(perif_cond[i]);
      end
    end
  end

  // Ready is seen on the port 16 clocks after the enable bit sets, counting the output
  // register, so the count stops one short of the settle constant.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mem_rdy_r <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        settle_cnt_r[i] <= 5'h00;
      end
    end else if (clk_en) begin
      for (int i = 0; i < 2; i++) begin
        if (mem_en_r[i] && !mem_rdy_r[i]) begin
          if (settle_cnt_r[i] == (MEM_SETTLE_LAST - 5'h01)) begin
            mem_rdy_r[i] <= 1'b1;
          end else begin
            settle_cnt_r[i] <= settle_cnt_r[i] + 5'h01;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sdram_ctrl_enable     <= 1'b0;
      async_mem_port_enable <= 1'b0;
      sdram_ctrl_ready      <= 1'b0;
      async_mem_port_ready  <= 1'b0;
    end else if (clk_en) begin
      sdram_ctrl_enable     <= mem_en_r[SDRAM_CTRL_ENABLE_BIT];
      async_mem_port_enable <= mem_en_r[ASYNC_MEM_ENABLE_BIT];
      sdram_ctrl_ready      <= mem_rdy_r[SDRAM_CTRL_ENABLE_BIT];
      async_mem_port_ready  <= mem_rdy_r[ASYNC_MEM_ENABLE_BIT];
    end
  end

endmodule

// [pkg/perif_regs_pkg.sv]
// Constants, types and field layout for the peripheral enable and status register block.
// Functional notes
// - Bit 1 write 1 enables SDRAM controller.
// - Bit 0 write 1 enables async memory port.
// - Enable bits sticky; only reset clears them.
// - Interface usable within 16 register clocks.
// - Pin-disabled interface cannot be enabled by software.
// - Async port enable resets 1 on 0100b boot.
// - No status fields for the two memories.
// - State fields 3 bits, four legal codes.
// - Report A: host, serial B, serial A fields.
// - Report A: two-wire, pin I/O, timer B fields.
// - Report A: timer A, MAC fields; rest reserved.
// - Report B: PCI state in bits 2:0.
// - Status registers are read-only.
package perif_regs_pkg;

  localparam logic [31:0] OFS_STATE_REPORT_A = 32'h02AC0014;
  localparam logic [31:0] OFS_STATE_REPORT_B = 32'h02AC0018;
  localparam logic [31:0] OFS_MEM_IF_ENABLE  = 32'h02AC002C;

  localparam int SDRAM_CTRL_ENABLE_BIT = 1;
  localparam int ASYNC_MEM_ENABLE_BIT  = 0;

  localparam logic [3:0] BOOT_ROM8_CODE = 4'h4;
  localparam logic [1:0] MEM_ENABLE_RESET = 2'h0;

  // Settle time of a memory interface after its enable is set, in register clocks.
  localparam int          MEM_SETTLE_CYCLES = 16;
  localparam logic [4:0]  MEM_SETTLE_LAST   = 5'(MEM_SETTLE_CYCLES - 1);

  localparam int HOST_PORT_LSB   = 27;
  localparam int SERIAL_B_LSB    = 24;
  localparam int SERIAL_A_LSB    = 21;
  localparam int TWO_WIRE_LSB    = 18;
  localparam int PIN_IO_LSB      = 15;
  localparam int TIMER_B_LSB     = 12;
  localparam int TIMER_A_LSB     = 9;
  localparam int ETH_MAC_LSB     = 6;
  localparam int PCI_PORT_LSB    = 0;

  localparam logic [2:0] STATE_RESET_VALUE = 3'h0;

  typedef enum logic [2:0] {
    ST_DISABLED    = 3'h0,
    ST_ENABLED     = 3'h1,
    ST_POWERDOWN   = 3'h3,
    ST_IN_PROGRESS = 3'h5
  } perif_state_e;

  // Live condition of one on-chip peripheral, as its power controller reports it.
  typedef struct packed {
    logic powered_down;
    logic enable_req;
    logic enable_done;
  } perif_cond_s;

  localparam int NUM_PERIF = 9;

  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } wb_req_s;

endpackage

// [test/perif_regs_monitor.sv]
// Port checker for the enable and status register block.
`timescale 1ns/1ps
module perif_regs_monitor
  import perif_regs_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire wb_req_s     wb_req,
  input wire logic        sdram_pin_allow,
  input wire logic        async_pin_allow,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sdram_ctrl_enable,
  input wire logic        async_mem_port_enable,
  input wire logic        sdram_ctrl_ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Matching again at the ack edge is harmless: the enable is sticky.
  sequence cfg_wr;
    wb_req.cyc & wb_req.stb & wb_req.we & wb_req.sel[0] & (wb_req.adr == OFS_MEM_IF_ENABLE);
  endsequence
  sequence rd_ack(logic [31:0] a);
    wb_ack_o & !wb_req.we & (wb_req.adr == a);
  endsequence
  sdram_set_a: assert property (cfg_wr ##0 wb_req.dat[1] & sdram_pin_allow |-> ##2 sdram_ctrl_enable)
    else $error("sdram enable missed");
  async_set_a: assert property (cfg_wr ##0 wb_req.dat[0] & async_pin_allow |-> ##2 async_mem_port_enable)
    else $error("async enable missed");
  sdram_hold_a: assert property (sdram_ctrl_enable |=> sdram_ctrl_enable)
    else $error("sdram enable cleared");
  async_hold_a: assert property (async_mem_port_enable |=> async_mem_port_enable)
    else $error("async enable cleared");
  sdram_block_a: assert property (!sdram_pin_allow |-> !sdram_ctrl_enable)
    else $error("blocked sdram enabled");
  sdram_ready_a: assert property ($rose(sdram_ctrl_enable) |-> ##[1:16] sdram_ctrl_ready)
    else $error("sdram ready late");
  report_a_zero_a: assert property (rd_ack(OFS_STATE_REPORT_A) |-> wb_dat_o[31:30] == 2'h0 && wb_dat_o[5:0] == 6'h00)
    else $error("report a reserved set");
  report_b_zero_a: assert property (rd_ack(OFS_STATE_REPORT_B) |-> wb_dat_o[31:3] == 29'h0)
    else $error("report b reserved set");
endmodule
bind perif_enable_status_regs perif_regs_monitor mon_u (.clk_sys, .reset, .wb_req,
  .sdram_pin_allow, .async_pin_allow, .wb_dat_o, .wb_ack_o, .sdram_ctrl_enable,
  .async_mem_port_enable, .sdram_ctrl_ready);

// [test/peripheral_enable_status_regs_test.sv]
// Self-checking bench for the enable and status register block.
`timescale 1ns/1ps
module peripheral_enable_status_regs_test
  import perif_regs_pkg::*;
;
  logic clk_sys = 1'b0, reset = 1'b1, clk_en = 1'b1;
  wb_req_s wb_req = '0;
  logic [3:0] boot_select_field = 4'h0;
  logic sdram_pin_allow = 1'b0, async_pin_allow = 1'b0;
  perif_cond_s [NUM_PERIF-1:0] perif_cond = '0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, sdram_ctrl_enable, async_mem_port_enable, sdram_ctrl_ready, async_mem_port_ready;
  int bad_count = 0, total_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  perif_enable_status_regs dut_u (.clk_sys, .reset, .clk_en, .wb_req, .boot_select_field,
    .sdram_pin_allow, .async_pin_allow, .perif_cond, .wb_dat_o, .wb_ack_o,
    .sdram_ctrl_enable, .async_mem_port_enable, .sdram_ctrl_ready, .async_mem_port_ready);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic [31:0] a, d, input logic w);
    int n;
    n = 0;
    wb_req <= '{a, d, 4'hF, w, 1'b1, 1'b1};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      $display("mismatch ack expected 1 seen %b", wb_ack_o);
      complete_run();
    end
    q = wb_dat_o;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic restart(input logic [3:0] b, input logic p);
    reset <= 1'b1;
    boot_select_field <= b;
    sdram_pin_allow <= p;
    async_pin_allow <= p;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic pin_blocked;
    restart(4'h0, 1'b0);
    bus(OFS_MEM_IF_ENABLE, 32'h3, 1'b1);
    bus(OFS_MEM_IF_ENABLE, 32'h0, 1'b0);
    chk("blocked", 32'h0, q);
  endtask
  task automatic status_layout;
    perif_cond <= {3'h4, 3'h2, 3'h3, 3'h0, 3'h4, 3'h2, 3'h3, 3'h0, 3'h2};
    bus(OFS_STATE_REPORT_B, 32'h7, 1'b1);
    bus(OFS_STATE_REPORT_A, 32'h0, 1'b0);
    chk("report a", {2'h0, 3'h3, 3'h5, 3'h1, 3'h0, 3'h3, 3'h5, 3'h1, 3'h0, 6'h00}, q);
    bus(OFS_STATE_REPORT_B, 32'h0, 1'b0);
    chk("report b", 32'h5, q);
    bus(32'h02AC0010, 32'h0, 1'b0);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic sticky_enable;
    restart(BOOT_ROM8_CODE, 1'b1);
    bus(OFS_MEM_IF_ENABLE, 32'h0, 1'b0);
    chk("boot enable", 32'h1, q);
    bus(OFS_MEM_IF_ENABLE, 32'h3, 1'b1);
    bus(OFS_MEM_IF_ENABLE, 32'h0, 1'b1);
    bus(OFS_MEM_IF_ENABLE, 32'h0, 1'b0);
    chk("sticky", 32'h3, q);
    repeat (MEM_SETTLE_CYCLES) @(posedge clk_sys);
    chk("ready", 32'h3, {30'h0, sdram_ctrl_ready, async_mem_port_ready});
    chk("enables", 32'h3, {30'h0, sdram_ctrl_enable, async_mem_port_enable});
  endtask
  initial begin
    pin_blocked();
    status_layout();
    sticky_enable();
    complete_run();
  end
endmodule
